// *** rtl/gpc_pkg.sv ***
// constants, register map and source encodings for the general purpose control ports
package gpc_pkg;
   localparam int unsigned NUM_PORTS = 8;
   localparam int unsigned NUM_OD_PORTS = 7;
   localparam int unsigned NUM_USER_KEYS = 12;
   localparam int unsigned NUM_SCOPES = 4;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;

   // register word addresses
   localparam logic [3:0] ADDR_IN_STATUS = 4'h0;
   localparam logic [3:0] ADDR_IN_MODE = 4'h1;
   localparam logic [3:0] ADDR_IN_MODE_TOGGLE = 4'h2;
   localparam logic [3:0] ADDR_IN_POL = 4'h3;
   localparam logic [3:0] ADDR_IN_FUNC = 4'h4;
   localparam logic [3:0] ADDR_OUT_STATUS = 4'h5;
   localparam logic [3:0] ADDR_OUT_POL = 4'h6;
   localparam logic [3:0] ADDR_OUT_TEST = 4'h7;
   localparam logic [3:0] ADDR_OUT_SRC_BASE = 4'h8;

   // reset values
   localparam logic [7:0] RST_IN_MODE = 8'h00;
   localparam logic [7:0] RST_IN_POL = 8'h00;
   localparam logic [7:0] RST_OUT_POL = 8'h00;
   localparam logic [7:0] RST_OUT_TEST = 8'h00;
   localparam logic [11:0] RST_OUT_SRC = 12'h000;

   // output source word layout
   localparam int unsigned SRC_W = 12;
   localparam int unsigned SRC_KIND_LSB = 0;
   localparam int unsigned SRC_SUB_LSB = 4;
   localparam int unsigned SRC_BUS_BIT = 6;
   localparam int unsigned SRC_IDX_LSB = 8;

   typedef enum logic [2:0] {
      GPC_SRC_NONE = 3'h0,
      GPC_SRC_MONITOR = 3'h1,
      GPC_SRC_ENGINE = 3'h2,
      GPC_SRC_INPUT_FUNC = 3'h3,
      GPC_SRC_USER_KEY = 3'h4
   } gpc_src_kind_t;

   // monitor-select scopes
   localparam logic [1:0] SCOPE_SELECTED_CHANNEL = 2'h0;
   localparam logic [1:0] SCOPE_GROUP_ONLY = 2'h1;
   localparam logic [1:0] SCOPE_INPUT_ONLY = 2'h2;
   localparam logic [1:0] SCOPE_OUTPUT_ONLY = 2'h3;

   // engine mirroring conditions
   localparam logic [1:0] ENG_CHANGEOVER = 2'h0;
   localparam logic [1:0] ENG_A_ACTIVE = 2'h1;
   localparam logic [1:0] ENG_B_ACTIVE = 2'h2;
endpackage

// *** rtl/gpc_src_if.sv ***
// source state shared by all output channels
`timescale 1ns/100ps
interface gpc_src_if;
   logic [gpc_pkg::NUM_SCOPES-1:0] cue_a;
   logic [gpc_pkg::NUM_SCOPES-1:0] cue_b;
   logic eng_changeover;
   logic eng_a_active;
   logic eng_b_active;
   logic [gpc_pkg::NUM_PORTS-1:0] in_func;
   logic [gpc_pkg::NUM_USER_KEYS-1:0] user_key;
   modport producer(output cue_a, cue_b, eng_changeover, eng_a_active, eng_b_active, in_func, user_key);
   modport consumer(input cue_a, cue_b, eng_changeover, eng_a_active, eng_b_active, in_func, user_key);
endinterface

// *** rtl/gpc_in_chan.sv ***
// one input port: synchroniser, polarity and switch interpretation
`timescale 1ns/100ps
module gpc_in_chan (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic pin_in,
   input wire logic low_active,
   input wire logic released_switch_mode,
   output logic level,
   output logic func_active
);
   logic sync1_reg;
   logic sync2_reg;
   logic prev_reg;
   logic func_reg;
   logic asserted;

   // two stages before anything looks at the pin
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   assign level = sync2_reg;
   assign asserted = sync2_reg ^ low_active;

   // edge memory for the momentary interpretation
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= asserted;
      end
   end

   // momentary switch toggles on each press, alternate switch is followed as is
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         func_reg <= 1'b0;
      end else if (released_switch_mode) begin
         if (asserted && !prev_reg) begin
            func_reg <= ~func_reg;
         end
      end else begin
         func_reg <= asserted;
      end
   end

   assign func_active = func_reg;
endmodule

// *** rtl/gpc_out_chan.sv ***
// one output port: source select, test override and polarity
`timescale 1ns/100ps
module gpc_out_chan (
   input wire logic clk_sys,
   input wire logic rst,
   gpc_src_if.consumer src,
   input wire logic [gpc_pkg::SRC_W-1:0] src_cfg,
   input wire logic invert,
   input wire logic test_on,
   output logic level
);
   logic [2:0] kind;
   logic [1:0] sub;
   logic bus_b;
   logic [3:0] idx;
   logic src_asserted;
   logic level_reg;

   assign kind = src_cfg[gpc_pkg::SRC_KIND_LSB +: 3];
   assign sub = src_cfg[gpc_pkg::SRC_SUB_LSB +: 2];
   assign bus_b = src_cfg[gpc_pkg::SRC_BUS_BIT];
   assign idx = src_cfg[gpc_pkg::SRC_IDX_LSB +: 4];

   // asserted state of the selected source; unknown codes stay deasserted, but input indices 8..15 wrap onto inputs 0..7
   always_comb begin
      src_asserted = 1'b0;
      case (kind)
         gpc_pkg::GPC_SRC_MONITOR: begin
            src_asserted = bus_b ? src.cue_b[sub] : src.cue_a[sub];
         end
         gpc_pkg::GPC_SRC_ENGINE: begin
            if (sub == gpc_pkg::ENG_CHANGEOVER) begin
               src_asserted = src.eng_changeover;
            end else if (sub == gpc_pkg::ENG_A_ACTIVE) begin
               src_asserted = src.eng_a_active;
            end else if (sub == gpc_pkg::ENG_B_ACTIVE) begin
               src_asserted = src.eng_b_active;
            end
         end
         gpc_pkg::GPC_SRC_INPUT_FUNC: begin
            src_asserted = src.in_func[idx[2:0]];
         end
         gpc_pkg::GPC_SRC_USER_KEY: begin
            // key indices 12..15 do not exist and read as off
            if (idx < 4'(gpc_pkg::NUM_USER_KEYS)) begin
               src_asserted = src.user_key[idx];
            end
         end
         default: begin
            src_asserted = 1'b0;
         end
      endcase
   end

   // registered so the pin never glitches while the source word is rewritten
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         level_reg <= 1'b0;
      end else begin
         level_reg <= (test_on | src_asserted) ^ invert;
      end
   end

   assign level = level_reg;
endmodule

// *** rtl/gpc_top.sv ***
// general purpose control ports: register file, eight inputs, eight outputs
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
module gpc_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [gpc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [gpc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [gpc_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [gpc_pkg::NUM_PORTS-1:0] gpc_in_pin,
   input wire logic [gpc_pkg::NUM_SCOPES-1:0] cue_a_on,
   input wire logic [gpc_pkg::NUM_SCOPES-1:0] cue_b_on,
   input wire logic engine_changeover_event,
   input wire logic engine_a_active,
   input wire logic engine_b_active,
   input wire logic [gpc_pkg::NUM_USER_KEYS-1:0] user_key_active,
   output logic [gpc_pkg::NUM_OD_PORTS-1:0] gpc_od_o,
   output logic [gpc_pkg::NUM_OD_PORTS-1:0] gpc_od_oe,
   output logic gpc_relay_o
);
   localparam int unsigned N = gpc_pkg::NUM_PORTS;

   logic [N-1:0] in_mode_reg;
   logic [N-1:0] in_mode_next;
   logic [N-1:0] in_pol_reg;
   logic [N-1:0] out_pol_reg;
   logic [N-1:0] out_test_reg;
   logic [gpc_pkg::SRC_W-1:0] out_src_reg [N];
   logic [N-1:0] in_level;
   logic [N-1:0] in_func;
   logic [N-1:0] out_level;
   logic [gpc_pkg::DATA_W-1:0] rdata_reg;
   logic [gpc_pkg::DATA_W-1:0] rdata_next;
   logic src_sel;

   gpc_src_if src_bus();

   // source state gathered for the output channels
   assign src_bus.cue_a = cue_a_on;
   assign src_bus.cue_b = cue_b_on;
   assign src_bus.eng_changeover = engine_changeover_event;
   assign src_bus.eng_a_active = engine_a_active;
   assign src_bus.eng_b_active = engine_b_active;
   assign src_bus.in_func = in_func;
   assign src_bus.user_key = user_key_active;

   // toggle register flips mode bits written as one; plain write replaces them
   always_comb begin
      in_mode_next = in_mode_reg;
      if (reg_wr && reg_addr == gpc_pkg::ADDR_IN_MODE) begin
         in_mode_next = reg_wdata[N-1:0];
      end else if (reg_wr && reg_addr == gpc_pkg::ADDR_IN_MODE_TOGGLE) begin
         in_mode_next = in_mode_reg ^ reg_wdata[N-1:0];
      end
   end

   // input configuration; no scene input reaches these, so they stay global
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         in_mode_reg <= gpc_pkg::RST_IN_MODE;
         in_pol_reg <= gpc_pkg::RST_IN_POL;
      end else begin
         in_mode_reg <= in_mode_next;
         if (reg_wr && reg_addr == gpc_pkg::ADDR_IN_POL) begin
            in_pol_reg <= reg_wdata[N-1:0];
         end
      end
   end

   // output polarity and test controls
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         out_pol_reg <= gpc_pkg::RST_OUT_POL;
         out_test_reg <= gpc_pkg::RST_OUT_TEST;
      end else if (reg_wr) begin
         if (reg_addr == gpc_pkg::ADDR_OUT_POL) begin
            out_pol_reg <= reg_wdata[N-1:0];
         end
         if (reg_addr == gpc_pkg::ADDR_OUT_TEST) begin
            out_test_reg <= reg_wdata[N-1:0];
         end
      end
   end

   // upper half of the map holds one source word per output
   assign src_sel = reg_addr[gpc_pkg::ADDR_W-1];

   generate
      for (genvar i = 0; i < N; i++) begin : g_port
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               out_src_reg[i] <= gpc_pkg::RST_OUT_SRC;
            end else if (reg_wr && src_sel && reg_addr[2:0] == 3'(i)) begin
               out_src_reg[i] <= reg_wdata[gpc_pkg::SRC_W-1:0];
            end
         end

         gpc_in_chan u_in (
            .clk_sys(clk_sys),
            .rst(rst),
            .pin_in(gpc_in_pin[i]),
            .low_active(in_pol_reg[i]),
            .released_switch_mode(in_mode_reg[i]),
            .level(in_level[i]),
            .func_active(in_func[i])
         );

         gpc_out_chan u_out (
            .clk_sys(clk_sys),
            .rst(rst),
            .src(src_bus.consumer),
            .src_cfg(out_src_reg[i]),
            .invert(out_pol_reg[i]),
            .test_on(out_test_reg[i]),
            .level(out_level[i])
         );
      end

      for (genvar j = 0; j < gpc_pkg::NUM_OD_PORTS; j++) begin : g_od
         // high level means released; only a low level enables the pull-down
         assign gpc_od_o[j] = 1'b0;
         assign gpc_od_oe[j] = ~out_level[j];
      end
   endgenerate

   // the last port is a relay contact, driven as a plain level
   assign gpc_relay_o = out_level[N-1];

   // read mux; unmapped words and unused bits read zero
   always_comb begin
      rdata_next = '0;
      if (src_sel) begin
         rdata_next[gpc_pkg::SRC_W-1:0] = out_src_reg[reg_addr[2:0]];
      end else begin
         case (reg_addr)
            gpc_pkg::ADDR_IN_STATUS: rdata_next[N-1:0] = in_level;
            gpc_pkg::ADDR_IN_MODE: rdata_next[N-1:0] = in_mode_reg;
            gpc_pkg::ADDR_IN_MODE_TOGGLE: rdata_next[N-1:0] = in_mode_reg;
            gpc_pkg::ADDR_IN_POL: rdata_next[N-1:0] = in_pol_reg;
            gpc_pkg::ADDR_IN_FUNC: rdata_next[N-1:0] = in_func;
            gpc_pkg::ADDR_OUT_STATUS: rdata_next[N-1:0] = out_level;
            gpc_pkg::ADDR_OUT_POL: rdata_next[N-1:0] = out_pol_reg;
            gpc_pkg::ADDR_OUT_TEST: rdata_next[N-1:0] = out_test_reg;
            default: rdata_next = '0;
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_reg <= '0;
      end else if (reg_rd) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= '0;
      end
   end

   assign reg_rdata = rdata_reg;
endmodule

// *** tb/gpc_top_checker.sv ***
// concurrent checks on the ports of the general purpose control block
`timescale 1ns/100ps
module gpc_top_checker (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [7:0] gpc_in_pin,
   input wire logic [3:0] cue_a_on,
   input wire logic [3:0] cue_b_on,
   input wire logic engine_changeover_event,
   input wire logic engine_a_active,
   input wire logic engine_b_active,
   input wire logic [11:0] user_key_active,
   input wire logic [6:0] gpc_od_o,
   input wire logic [6:0] gpc_od_oe,
   input wire logic gpc_relay_o
);
   logic [7:0] lvl;
   logic [7:0] pol_reg;
   logic [7:0] test_reg;
   logic [11:0] src_reg [8];
   logic [7:0] src_now;
   logic [7:0] skip;
   logic [7:0] idle;
   logic [7:0] exp_reg;
   // level per port: a released open-drain line reads high
   assign lvl = {gpc_relay_o, ~gpc_od_oe};
   // shadow of the output setup, rebuilt from bus writes
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pol_reg <= 8'h00;
         test_reg <= 8'h00;
         src_reg <= '{default: 12'h000};
      end else if (reg_wr) begin
         if (reg_addr == gpc_pkg::ADDR_OUT_POL) pol_reg <= reg_wdata[7:0];
         if (reg_addr == gpc_pkg::ADDR_OUT_TEST) test_reg <= reg_wdata[7:0];
         if (reg_addr[3]) src_reg[reg_addr[2:0]] <= reg_wdata[11:0];
      end
   end
   // source state per port; input functions are internal, so those ports are skipped
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         skip[i] = src_reg[i][2:0] == 3'h3;
         idle[i] = src_reg[i][2:0] == 3'h0 || src_reg[i][2:0] > 3'h4;
         case (src_reg[i][2:0])
            3'h1: src_now[i] = src_reg[i][6] ? cue_b_on[src_reg[i][5:4]] : cue_a_on[src_reg[i][5:4]];
            3'h2: src_now[i] = (src_reg[i][5:4] == 2'h0 && engine_changeover_event) ||
               (src_reg[i][5:4] == 2'h1 && engine_a_active) || (src_reg[i][5:4] == 2'h2 && engine_b_active);
            3'h4: src_now[i] = src_reg[i][11:8] < 4'hc && user_key_active[src_reg[i][11:8]];
            default: src_now[i] = 1'b0;
         endcase
      end
   end
   // expected level, one edge behind its cause
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) exp_reg <= 8'h00;
      else exp_reg <= (test_reg | src_now) ^ pol_reg;
   end
   a_od_data_low: assert property (@(posedge clk_sys) disable iff (rst) gpc_od_o == 7'h00)
      else $error("open-drain data not low");
   a_reset_pulls_low: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(rst) |-> gpc_od_oe == 7'h7f && !gpc_relay_o) else $error("outputs not idle after reset");
   a_rdata_idle_zero: assert property (@(posedge clk_sys) disable iff (rst)
      !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside its cycle");
   a_out_status_view: assert property (@(posedge clk_sys) disable iff (rst)
      reg_rd && reg_addr == gpc_pkg::ADDR_OUT_STATUS |=> reg_rdata[7:0] == $past(lvl))
      else $error("output status differs from driven level");
   a_in_status_view: assert property (@(posedge clk_sys) disable iff (rst)
      reg_rd && reg_addr == gpc_pkg::ADDR_IN_STATUS && !$past(rst) && !$past(rst, 2)
      |=> reg_rdata[7:0] == $past(gpc_in_pin, 3)) else $error("input status differs from pin");
   a_test_forces_on: assert property (@(posedge clk_sys) disable iff (rst)
      ($past(test_reg) & ~(lvl ^ $past(pol_reg))) == 8'h00) else $error("test port not asserted");
   a_src_level_map: assert property (@(posedge clk_sys) disable iff (rst)
      ((lvl ^ exp_reg) & ~$past(skip)) == 8'h00) else $error("output level differs from source");
   a_unassigned_idle: assert property (@(posedge clk_sys) disable iff (rst)
      ($past(idle) & ~$past(test_reg) & (lvl ^ $past(pol_reg))) == 8'h00) else $error("unassigned port asserted");
endmodule
bind gpc_top gpc_top_checker i_gpc_top_checker (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .gpc_in_pin, .cue_a_on, .cue_b_on, .engine_changeover_event, .engine_a_active,
   .engine_b_active, .user_key_active, .gpc_od_o, .gpc_od_oe, .gpc_relay_o);

// *** tb/gpc_field_model.sv ***
// external switches, lamps and relay on the far side of the ports
`timescale 1ns/100ps
module gpc_field_model (
   input wire logic [7:0] sw_closed,
   input wire logic [6:0] od_o,
   input wire logic [6:0] od_oe,
   input wire logic relay_o,
   output logic [7:0] pin,
   output logic [7:0] wire_lvl
);
   // each switch shorts its pin to ground against a pull-up, so closed reads low
   assign pin = ~sw_closed;
   // a released line floats up; a driven one shows whatever the port drives, high included
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         wire_lvl[i] = od_oe[i] ? od_o[i] : 1'b1;
      end
      wire_lvl[7] = relay_o;
   end
endmodule

// *** tb/test_gpc_top.sv ***
// self-checking testbench for the general purpose control ports
`timescale 1ns/100ps
module test_gpc_top;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [3:0] cue_a = 4'h5;
   logic [3:0] cue_b = 4'h2;
   logic [11:0] ukey = 12'h801;
   // engine states as {changeover, a active, b active}
   logic [2:0] eng = 3'h5;
   logic [7:0] sw_closed = 8'h00;
   logic [7:0] pin;
   logic [7:0] wire_lvl;
   logic [6:0] od_o;
   logic [6:0] od_oe;
   logic relay;
   logic [31:0] rv;
   logic f0;
   logic [12:0] tab [13] = '{13'h1002, 13'h0012, 13'h1022, 13'h0032, 13'h0003, 13'h1103, 13'h0703,
      13'h1004, 13'h1b04, 13'h0504, 13'h0c04, 13'h0000, 13'h0005};
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   always #5 clk_sys = ~clk_sys;
   gpc_top i_gpc_top (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpc_in_pin(pin), .cue_a_on(cue_a),
      .cue_b_on(cue_b), .engine_changeover_event(eng[2]), .engine_a_active(eng[1]), .engine_b_active(eng[0]),
      .user_key_active(ukey), .gpc_od_o(od_o), .gpc_od_oe(od_oe), .gpc_relay_o(relay));
   gpc_field_model i_gpc_field_model (.sw_closed(sw_closed), .od_o(od_o), .od_oe(od_oe), .relay_o(relay),
      .pin(pin), .wire_lvl(wire_lvl));
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   // strobes go up right after an edge and drop after the next one
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string n);
      rd(a, rv);
      chk(n, e, rv);
   endtask
   // one source word on one port, status bit compared
   task automatic src_case(input int n, input logic [11:0] w, input logic e);
      wr(4'h8 + n[2:0], {20'h0, w});
      repeat (3) @(posedge clk_sys);
      rd(4'h5, rv);
      chk("source", {31'h0, e}, {31'h0, rv[n % 8]});
      wr(4'h8 + n[2:0], 32'h0);
   endtask
   // hang guard, far above the expected run length
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         conclude();
      end
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      // let the synchronisers fill with the idle pin level before status is read
      repeat (2) @(posedge clk_sys);
      for (int a = 0; a < 16; a++) rdchk(a[3:0], (a == 0 || a == 4) ? 32'hff : 32'h0, "reset");
      chk("wire", 32'h0, {24'h0, wire_lvl});
      wr(4'h5, 32'hff);
      wr(4'h4, 32'h0);
      rdchk(4'h5, 32'h0, "out status");
      rdchk(4'h4, 32'hff, "in func");
      wr(4'h3, 32'hff);
      rdchk(4'h3, 32'hff, "in pol");
      @(posedge clk_sys) sw_closed <= 8'h04;
      repeat (4) @(posedge clk_sys);
      rdchk(4'h0, 32'hfb, "in status");
      rdchk(4'h4, 32'h04, "in func");
      @(posedge clk_sys) sw_closed <= 8'h02;
      repeat (4) @(posedge clk_sys);
      rdchk(4'h4, 32'h02, "in func");
      wr(4'h6, 32'h5a);
      // test on the relay port too, so the relay pin is seen high once
      wr(4'h7, 32'hbc);
      repeat (2) @(posedge clk_sys);
      rdchk(4'h5, 32'he6, "out status");
      chk("wire", 32'he6, {24'h0, wire_lvl});
      wr(4'h6, 32'h0);
      wr(4'h7, 32'h0);
      for (int k = 0; k < 13; k++) src_case(k, tab[k][11:0], tab[k][12]);
      // swap the engine states so each engine condition is seen both ways
      @(posedge clk_sys) eng <= 3'h2;
      for (int k = 0; k < 3; k++) src_case(k, tab[k][11:0], ~tab[k][12]);
      for (int k = 0; k < 8; k++) src_case(k, 12'h001 | (k[1:0] << 4) | (k[2] << 6),
         k[2] ? cue_b[k[1:0]] : cue_a[k[1:0]]);
      wr(4'h2, 32'h04);
      rdchk(4'h1, 32'h04, "mode");
      wr(4'h2, 32'h05);
      rdchk(4'h1, 32'h01, "mode");
      // one toggle write clears port 0 and makes port 2 momentary
      wr(4'h2, 32'h05);
      rdchk(4'h1, 32'h04, "mode");
      rd(4'h4, rv);
      f0 = rv[2];
      for (int k = 1; k <= 2; k++) begin
         @(posedge clk_sys) sw_closed <= 8'h06;
         repeat (4) @(posedge clk_sys);
         @(posedge clk_sys) sw_closed <= 8'h02;
         repeat (4) @(posedge clk_sys);
         rdchk(4'h4, {29'h0, f0 ^ k[0], 2'h2}, "momentary");
      end
      conclude();
   end
endmodule
